// File: led_gray_pkg.sv
/*
 * constants shared by the grayscale pwm engine: the setup_word layout,
 * the reset value, the counting figures and the timing counts.
 * assumes a 10 MHz system clock.
 */
// Contract
// - hot die sets thermal flag, readable
// - keep only 12 bits per data word
// - split mode: 64 msb segments, one lsb
// - direct mode: one 4096-clock 12-bit count
// - bit C: 0 split, 1 direct default
// - auto sync loads after cycle completes
// - auto sync renews at segment boundary; code loads only at the cycle end
// - manual sync loads data immediately
// - bit 0 low: blank after 1 s
// - resume on clock plus new data
// - gain from bits 9 to 2
// - bit 9 range, bits 8-2 mantissa
// - mantissa relates to gain by formula
// - default gain field means gain 1
// - four output groups staggered 2 ns; code staggers them by one 100 ns clock each
package led_gray_pkg;
	localparam int CHANNELS = 16;
	localparam int GRAY_W = 12;
	localparam int SEG_W = 6;
	// setup_word field positions
	localparam int LOAD_MODE_BIT = 15;
	localparam int THERMAL_BIT = 14;
	localparam int RESERVED_BIT = 13;
	localparam int COUNT_MODE_BIT = 12;
	localparam int CNT_RESET_EN_BIT = 11;
	localparam int SYNC_MODE_BIT = 10;
	localparam int GAIN_HI = 9;
	localparam int GAIN_LO = 2;
	localparam int TP_EN_BIT = 1;
	localparam int TIMEOUT_DIS_BIT = 0;
	localparam logic [15:0] SETUP_RESET = 16'h32AC;
	// bits software may change; E and D are read only
	localparam logic [15:0] SETUP_WMASK = 16'h9FFF;
	// split and direct counting figures
	localparam logic [5:0] MSB_SEG_LAST = 6'h3E;
	localparam logic [6:0] LSB_SEG_INDEX = 7'h40;
	localparam logic [5:0] LSB_SEG_LAST = 6'h3F;
	localparam logic [11:0] DIRECT_LAST = 12'hFFF;
	// gain numerator offset: G = (3*D + 128) / 2^shift
	localparam logic [8:0] GAIN_OFFSET = 9'h080;
	localparam logic [3:0] GAIN_SHIFT_HI = 4'h8;
	localparam logic [3:0] GAIN_SHIFT_LO = 4'hA;
	// timing
	localparam int CLK_HZ = 10_000_000;
	localparam int CLK_PERIOD_NS = 100;
	localparam int TIMEOUT_S = 1;
	localparam int TIMEOUT_CYC = TIMEOUT_S * CLK_HZ;
	localparam int STAGGER_NS = 2;
	localparam int STAGGER_CYC_RAW = STAGGER_NS / CLK_PERIOD_NS;
	localparam int STAGGER_CYC = (STAGGER_CYC_RAW < 1) ? 1 : STAGGER_CYC_RAW;
endpackage

// File: pin_sync.sv
/*
 * two flip-flop synchroniser for pins from outside the clock domain,
 * with a rising edge pulse taken from the settled copy.
 * assumes inputs are asynchronous to sys_clk.
 */
`timescale 1ns/1ns
module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [WIDTH-1:0] pin,
	output logic [WIDTH-1:0] level,
	output logic [WIDTH-1:0] rise
);
	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] prev;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			meta <= '0;
			level <= '0;
			prev <= '0;
		end else begin
			meta <= pin;
			level <= meta;
			prev <= level;
		end
	end

	assign rise = level & ~prev;
endmodule

// File: out_stagger.sv
/*
 * staggers the sink drive in four groups by channel index mod 4,
 * each group one step later than the one before.
 * assumes the step is given in whole system clock cycles.
 */
`timescale 1ns/1ns
module out_stagger #(
	parameter int CHANNELS = 16,
	parameter int STEP = 1
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [CHANNELS-1:0] drive_in,
	output logic [CHANNELS-1:0] drive_out
);
	// a cycle is far longer than the nominal step; the order is what limits
	// the inrush, so group g lags group 0 by g steps
	localparam int DEPTH = 3 * STEP + 1;
	logic [CHANNELS-1:0] pipe [DEPTH];

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < DEPTH; i++) begin
				pipe[i] <= '0;
			end
		end else begin
			pipe[0] <= drive_in;
			for (int i = 1; i < DEPTH; i++) begin
				pipe[i] <= pipe[i-1];
			end
		end
	end

	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch++) begin : g_ch
			assign drive_out[ch] = pipe[(ch % 4) * STEP][ch];
		end
	endgenerate
endmodule

// File: led_gray_pwm_counter.sv
/*
 * grayscale pwm engine: shadow and active gray buffers, split or direct
 * counting on grayscale clock edges, load synchronisation, clock loss
 * blanking, thermal flag and gain field decode.
 * assumes the serial command decoder runs on sys_clk and hands over
 * words, latch strobes and setup writes as one-cycle pulses.
 */
`timescale 1ns/1ns
module led_gray_pwm_counter #(
	parameter int TIMEOUT_CYC = led_gray_pkg::TIMEOUT_CYC
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic grayscale_clock,
	input wire logic over_temp,
	input wire logic data_write,
	input wire logic [3:0] data_channel,
	input wire logic [15:0] data_word,
	input wire logic global_latch,
	input wire logic setup_write,
	input wire logic [15:0] setup_wdata,
	input wire logic counter_reset_cmd,
	output logic [15:0] setup_word,
	output logic [led_gray_pkg::CHANNELS-1:0] sink_output_group,
	output logic gain_range_select,
	output logic [6:0] gain_mantissa,
	output logic [8:0] gain_numerator,
	output logic [3:0] gain_shift,
	output logic current_quarter,
	output logic outputs_blanked
);
	localparam int CH = led_gray_pkg::CHANNELS;
	localparam int GW = led_gray_pkg::GRAY_W;
	localparam int TW = $clog2(TIMEOUT_CYC + 1);
	localparam logic [TW-1:0] TIMEOUT_LAST = TW'(TIMEOUT_CYC - 1);

	logic [15:0] setup_store;
	logic [GW-1:0] shadow [CH];
	logic [GW-1:0] active [CH];
	logic pending;
	logic [11:0] dcnt;
	logic [6:0] seg;
	logic [5:0] spos;
	logic blank;
	logic clk_back;
	logic [TW-1:0] idle_cnt;
	logic [CH-1:0] drive;
	logic grayscale_clock_level;
	logic grayscale_clock_rise;
	logic hot;

	pin_sync #(.WIDTH(1)) u_grayscale_clock_sync (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.pin(grayscale_clock),
		.level(grayscale_clock_level),
		.rise(grayscale_clock_rise)
	);

	pin_sync #(.WIDTH(1)) u_temp_sync (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.pin(over_temp),
		.level(hot),
		.rise()
	);

	wire direct_mode = setup_store[led_gray_pkg::COUNT_MODE_BIT];
	wire manual_sync = setup_store[led_gray_pkg::SYNC_MODE_BIT];
	wire timeout_en = ~setup_store[led_gray_pkg::TIMEOUT_DIS_BIT];
	wire cnt_reset = counter_reset_cmd
		& setup_store[led_gray_pkg::CNT_RESET_EN_BIT];
	wire resume = blank & clk_back & data_write;
	wire restart = cnt_reset | resume;
	wire seg_is_lsb = (seg == led_gray_pkg::LSB_SEG_INDEX);
	wire seg_last = seg_is_lsb ? (spos == led_gray_pkg::LSB_SEG_LAST)
		: (spos == led_gray_pkg::MSB_SEG_LAST);
	wire direct_end = (dcnt == led_gray_pkg::DIRECT_LAST);
	// a full cycle ends on a segment boundary in split mode
	wire cycle_end = grayscale_clock_rise & (direct_mode ? direct_end
		: (seg_last & seg_is_lsb));
	wire load_now = manual_sync ? global_latch
		: (pending & cycle_end);
	wire idle_out = timeout_en & (idle_cnt == TIMEOUT_LAST);

	// setup_word readback: live thermal flag, reserved bit reads one
	always_comb begin
		setup_word = setup_store;
		setup_word[led_gray_pkg::THERMAL_BIT] = hot;
		setup_word[led_gray_pkg::RESERVED_BIT] = 1'b1;
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			setup_store <= led_gray_pkg::SETUP_RESET;
		end else if (setup_write) begin
			setup_store <= (setup_wdata & led_gray_pkg::SETUP_WMASK)
				| (led_gray_pkg::SETUP_RESET & ~led_gray_pkg::SETUP_WMASK);
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < CH; i++) begin
				shadow[i] <= '0;
				active[i] <= '0;
			end
		end else begin
			if (data_write) begin
				shadow[data_channel] <= data_word[GW-1:0];
			end
			if (load_now) begin
				for (int i = 0; i < CH; i++) begin
					active[i] <= shadow[i];
				end
			end
		end
	end

	// a latch during the load cycle stays pending: set wins
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pending <= 1'b0;
		end else if (global_latch && !manual_sync) begin
			pending <= 1'b1;
		end else if (load_now || manual_sync) begin
			pending <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			dcnt <= '0;
			seg <= '0;
			spos <= '0;
		end else if (restart) begin
			dcnt <= '0;
			seg <= '0;
			spos <= '0;
		end else if (grayscale_clock_rise) begin
			dcnt <= dcnt + 12'h001;
			if (seg_last) begin
				spos <= '0;
				seg <= seg_is_lsb ? 7'h00 : seg + 7'h01;
			end else begin
				spos <= spos + 6'h01;
			end
		end
	end

	// timeout: no grayscale clock edge for the full count
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			idle_cnt <= '0;
			blank <= 1'b0;
			clk_back <= 1'b0;
		end else begin
			if (grayscale_clock_rise || !timeout_en) begin
				idle_cnt <= '0;
			end else if (!idle_out) begin
				idle_cnt <= idle_cnt + TW'(1);
			end
			if (idle_out && !grayscale_clock_rise) begin
				blank <= 1'b1;
				clk_back <= 1'b0;
			end else if (resume) begin
				blank <= 1'b0;
				clk_back <= 1'b0;
			end else if (blank && grayscale_clock_rise) begin
				clk_back <= 1'b1;
			end
		end
	end

	genvar ch;
	generate
		for (ch = 0; ch < CH; ch++) begin : g_cmp
			wire [5:0] msb = active[ch][11:6];
			wire [5:0] lsb = active[ch][5:0];
			wire split_on = seg_is_lsb ? (spos < lsb) : (spos < msb);
			wire on = direct_mode ? (dcnt < active[ch]) : split_on;
			always_ff @(posedge sys_clk or negedge nrst) begin
				if (!nrst) begin
					drive[ch] <= 1'b0;
				end else begin
					drive[ch] <= on & ~blank;
				end
			end
		end
	endgenerate

	out_stagger #(
		.CHANNELS(CH),
		.STEP(led_gray_pkg::STAGGER_CYC)
	) u_stagger (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.drive_in(drive),
		.drive_out(sink_output_group)
	);

	// gain field: range bit and mantissa, G = (3D + 128) / 2^shift
	wire [6:0] mant = setup_store[led_gray_pkg::GAIN_HI-1:led_gray_pkg::GAIN_LO];
	assign gain_range_select = setup_store[led_gray_pkg::GAIN_HI];
	assign gain_mantissa = mant;
	assign gain_numerator = {mant, 1'b0} + {2'b00, mant}
		+ led_gray_pkg::GAIN_OFFSET;
	assign gain_shift = gain_range_select ? led_gray_pkg::GAIN_SHIFT_HI
		: led_gray_pkg::GAIN_SHIFT_LO;
	assign current_quarter = hot & setup_store[led_gray_pkg::TP_EN_BIT];
	assign outputs_blanked = blank;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	// the pin reaches the flag through two flip-flops
	chk_thermal_flag: assert property (
		$past(nrst, 2) |-> setup_word[led_gray_pkg::THERMAL_BIT]
			== $past(over_temp, 2))
		else $error("thermal flag does not follow die state");
	chk_word_twelve_bits: assert property (
		data_write |=> shadow[$past(data_channel)] == $past(data_word[11:0]))
		else $error("shadow did not keep low twelve bits");
	chk_split_seg_wrap: assert property (
		grayscale_clock_rise && !restart && !seg_is_lsb && seg_last
		|=> spos == 6'h00 && seg == $past(seg) + 7'h01)
		else $error("msb segment did not end after 63 clocks");
	chk_direct_wrap: assert property (
		grayscale_clock_rise && !restart && direct_end |=> dcnt == 12'h000)
		else $error("direct count did not wrap after 4096");
	chk_auto_load_wait: assert property (
		!manual_sync && !cycle_end |=> $stable(active[0]) || $past(restart))
		else $error("auto sync loaded outside cycle end");
	chk_manual_load: assert property (
		manual_sync && global_latch && !data_write
		|=> active[3] == $past(shadow[3]))
		else $error("manual sync did not load at once");
	chk_timeout_blank: assert property (
		idle_out && !grayscale_clock_rise |=> blank ##1 drive == '0)
		else $error("outputs not blanked after clock loss");
	chk_resume_restart: assert property (
		resume |=> !blank && dcnt == 12'h000 && seg == 7'h00)
		else $error("resume did not restart counters");
	chk_gain_default: assert property (
		$rose(nrst) |-> {gain_range_select, gain_mantissa} == 8'hAB)
		else $error("gain field not at default after reset");
	chk_compare_on: assert property (
		direct_mode && !blank && dcnt < active[5] |=> drive[5])
		else $error("channel off while position below value");
endmodule

// File: grayscale_clock_host.sv
/*
 * host controller model: makes the grayscale clock at an 800 ns period.
 * assumes the bench raises run while a picture is being shown.
 */
`timescale 1ns/1ns
module grayscale_clock_host (
	input wire logic run,
	output logic grayscale_clock
);
	initial grayscale_clock = 1'b0;
	// free running while shown, parked low so a loss can be staged
	always #400 grayscale_clock <= run ? ~grayscale_clock : 1'b0;
endmodule

// File: testbench.sv
/*
 * self-checking bench for the grayscale pwm engine.
 * assumes the host model supplies the grayscale clock.
 */
`timescale 1ns/1ns
module testbench;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic run = 1'b0;
	logic grayscale_clock;
	logic over_temp = 1'b0;
	logic data_write = 1'b0;
	logic [3:0] data_channel = 4'h0;
	logic [15:0] data_word = 16'h0000;
	logic global_latch = 1'b0;
	logic setup_write = 1'b0;
	logic [15:0] setup_wdata = 16'h0000;
	logic counter_reset_cmd = 1'b0;
	logic quarter;
	logic [15:0] setup_word;
	logic [15:0] sink;
	logic range_sel;
	logic [6:0] mant;
	logic [8:0] num;
	logic [3:0] shift;
	logic blanked;
	int n_fail = 0;
	int n_compared = 0;

	always #50 sys_clk = ~sys_clk;

	grayscale_clock_host host_u (
		.run(run),
		.grayscale_clock(grayscale_clock)
	);

	led_gray_pwm_counter #(.TIMEOUT_CYC(200)) dut_u (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.grayscale_clock(grayscale_clock),
		.over_temp(over_temp),
		.data_write(data_write),
		.data_channel(data_channel),
		.data_word(data_word),
		.global_latch(global_latch),
		.setup_write(setup_write),
		.setup_wdata(setup_wdata),
		.counter_reset_cmd(counter_reset_cmd),
		.setup_word(setup_word),
		.sink_output_group(sink),
		.gain_range_select(range_sel),
		.gain_mantissa(mant),
		.gain_numerator(num),
		.gain_shift(shift),
		.current_quarter(quarter),
		.outputs_blanked(blanked)
	);

	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic finish_test;
		$display("compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// sample at the falling edge so the rising edge's updates have landed
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask

	task automatic setw(input logic [15:0] v);
		@(posedge sys_clk);
		setup_write <= 1'b1;
		setup_wdata <= v;
		@(posedge sys_clk);
		setup_write <= 1'b0;
		tick(2);
	endtask

	task automatic load(input logic [3:0] ch, input logic [15:0] w,
		input logic latch);
		@(posedge sys_clk);
		data_write <= 1'b1;
		data_channel <= ch;
		data_word <= w;
		@(posedge sys_clk);
		data_write <= 1'b0;
		global_latch <= latch;
		@(posedge sys_clk);
		global_latch <= 1'b0;
	endtask

	task automatic t_reset;
		tick(1);
		check("setup reset", setup_word, 16'h32AC);
		check("range", 16'(range_sel), 16'h0001);
		check("mantissa", 16'(mant), 16'h002B);
		check("numerator", 16'(num), 16'h0101);
		check("shift", 16'(shift), 16'h0008);
	endtask

	task automatic t_setup;
		setw(16'h1400);
		check("low band shift", 16'(shift), 16'h000A);
		check("low numerator", 16'(num), 16'h0080);
		setw(16'h16AE);
		check("setup readback", setup_word, 16'h36AE);
		check("quarter cold", 16'(quarter), 16'h0000);
		@(posedge sys_clk);
		over_temp <= 1'b1;
		tick(4);
		check("thermal flag", setup_word, 16'h76AE);
		check("quarter hot", 16'(quarter), 16'h0001);
		@(posedge sys_clk);
		over_temp <= 1'b0;
		tick(4);
		check("quarter cooled", 16'(quarter), 16'h0000);
	endtask

	// manual load: new values show at once, upper word bits dropped
	task automatic t_manual;
		@(posedge sys_clk);
		run <= 1'b1;
		tick(20);
		load(4'h0, 16'hFFFF, 1'b0);
		load(4'h5, 16'h0800, 1'b0);
		load(4'h1, 16'hF000, 1'b1);
		tick(10);
		check("manual ch0", 16'(sink[0]), 16'h0001);
		check("half value ch5", 16'(sink[5]), 16'h0001);
		check("upper bits", 16'(sink[1]), 16'h0000);
		check("unwritten ch2", 16'(sink[2]), 16'h0000);
	endtask

	// auto load: old value holds until the running cycle closes
	task automatic t_auto;
		setw(16'h12AC);
		load(4'h0, 16'h0000, 1'b1);
		tick(20);
		check("auto hold", 16'(sink[0]), 16'h0001);
		// the old value is off in the last position too, so look past it
		for (int i = 0; i < 40000 && sink[0] !== 1'b0; i++)
			tick(1);
		check("last position off", 16'(sink[0]), 16'h0000);
		if (sink[0] !== 1'b0)
			finish_test();
		tick(20);
		check("auto load", 16'(sink[0]), 16'h0000);
	endtask

	task automatic t_timeout;
		load(4'h0, 16'h0FFF, 1'b1);
		@(posedge sys_clk);
		run <= 1'b0;
		tick(300);
		check("blanked", 16'(blanked), 16'h0001);
		check("drives off", sink, 16'h0000);
		@(posedge sys_clk);
		run <= 1'b1;
		tick(20);
		check("still blanked", 16'(blanked), 16'h0001);
		load(4'h0, 16'h0FFF, 1'b0);
		tick(3);
		check("resumed", 16'(blanked), 16'h0000);
	endtask

	// split mode after a counter reset: on only at the segment start
	task automatic t_split;
		setw(16'h0EAC);
		load(4'h2, 16'h0041, 1'b1);
		@(posedge sys_clk);
		counter_reset_cmd <= 1'b1;
		@(posedge sys_clk);
		counter_reset_cmd <= 1'b0;
		tick(4);
		check("count restart", 16'(sink[2]), 16'h0001);
		tick(100);
		check("split segment off", 16'(sink[2]), 16'h0000);
		setw(16'h0EAD);
		@(posedge sys_clk);
		run <= 1'b0;
		tick(300);
		check("timeout disabled", 16'(blanked), 16'h0000);
	endtask

	initial begin
		repeat (6) @(posedge sys_clk);
		nrst <= 1'b1;
		t_reset();
		t_setup();
		t_manual();
		t_auto();
		t_timeout();
		t_split();
		finish_test();
	end
endmodule
